// [include/gsp_defines.svh]
`ifndef GSP_DEFINES_SVH
`define GSP_DEFINES_SVH

// word layout
`define GSP_WORD_W 12
`define GSP_ADDR_HI 11
`define GSP_ADDR_LO 10
`define GSP_DATA_W 10
`define GSP_MSB 11
// address that disables all gauges
`define GSP_ADDR_OFF 2'h3
`define GSP_ADDR_MAJOR 2'h0
`define GSP_ADDR_MINOR1 2'h1
`define GSP_ADDR_MINOR2 2'h2
`define GSP_MINOR_W 8
// reset values
`define GSP_WORD_RST 12'h000
`define GSP_MAJOR_RST 10'h000
`define GSP_MINOR_RST 8'h00

`endif

// [include/gsp_pkg.sv]
package gsp_pkg;

  typedef struct packed {
    logic [9:0] major;
    logic [7:0] minor1;
    logic [7:0] minor2;
    logic outputs_off;
  } gsp_gauge_t;

  typedef struct packed {
    logic sclk;
    logic load;
    logic sdi;
  } gsp_pins_t;

  typedef struct packed {
    gsp_pins_t s1;
    gsp_pins_t s2;
  } gsp_sync_t;

endpackage

// [src/gsp_sync2.sv]
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser for the serial pins
module gsp_sync2 (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire gsp_pkg::gsp_pins_t pins_in,
  output gsp_pkg::gsp_pins_t pins_out
);

  gsp_pkg::gsp_sync_t st_q;
  gsp_pkg::gsp_sync_t st_d;

  always_comb begin
    st_d = st_q;
    if (ce) begin
      st_d.s1 = pins_in;
      st_d.s2 = st_q.s1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pins_out = st_q.s2;

endmodule

`default_nettype wire

// [src/gsp_serial_port.sv]
`include "gsp_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module gsp_serial_port (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic sclk,
  input wire logic load,
  input wire logic sdi,
  input wire logic short_det,
  input wire logic thermal_sd,
  output logic sdo,
  output logic fault_n_o,
  output logic fault_n_oe,
  output gsp_pkg::gsp_gauge_t gauge,
  output logic drivers_on
);

  typedef struct packed {
    logic sclk_prev;
    logic load_prev;
    logic [`GSP_WORD_W-1:0] shreg;
    logic sdo;
    gsp_pkg::gsp_gauge_t gauge;
    logic fault_dis;
    logic flt_s1;
    logic flt_s2;
    logic fault_oe;
    logic drv_on;
  } gsp_state_t;

  gsp_state_t st_q;
  gsp_state_t st_d;
  gsp_pkg::gsp_pins_t pins_raw;
  gsp_pkg::gsp_pins_t pins;
  logic sclk_rise;
  logic sclk_fall;
  logic load_fall;
  logic [1:0] addr;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  assign pins_raw = '{sclk: sclk, load: load, sdi: sdi};

  gsp_sync2 u_sync (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .pins_in(pins_raw),
    .pins_out(pins)
  );

  assign sclk_rise = pins.sclk & ~st_q.sclk_prev;
  assign sclk_fall = ~pins.sclk & st_q.sclk_prev;
  assign load_fall = ~pins.load & st_q.load_prev;
  assign addr = st_q.shreg[`GSP_ADDR_HI:`GSP_ADDR_LO];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    if (ce) begin
      st_d.sclk_prev = pins.sclk;
      st_d.load_prev = pins.load;
      if (sclk_rise && pins.load) begin
        st_d.shreg = {st_q.shreg[`GSP_WORD_W-2:0], pins.sdi};
      end
      // last stage moves out on falling edge only
      if (sclk_fall) begin
        st_d.sdo = st_q.shreg[`GSP_MSB];
      end
      if (load_fall) begin
        st_d.gauge.outputs_off = (addr == `GSP_ADDR_OFF);
        case (addr)
          `GSP_ADDR_MAJOR: begin
            st_d.gauge.major = st_q.shreg[`GSP_DATA_W-1:0];
          end
          `GSP_ADDR_MINOR1: begin
            st_d.gauge.minor1 = st_q.shreg[`GSP_MINOR_W-1:0];
          end
          `GSP_ADDR_MINOR2: begin
            st_d.gauge.minor2 = st_q.shreg[`GSP_MINOR_W-1:0];
          end
          default: begin
          end
        endcase
      end
      // fault status comes from the analog side, another domain
      st_d.flt_s1 = short_det | thermal_sd;
      st_d.flt_s2 = st_q.flt_s1;
      st_d.fault_oe = st_q.flt_s2;
      // fault latches disable; strobe fall re-enables.
      // a fault still present at the strobe wins, set over clear
      if (st_q.flt_s2) begin
        st_d.fault_dis = 1'b1;
      end else if (load_fall) begin
        st_d.fault_dis = 1'b0;
      end
      st_d.drv_on = ~st_d.fault_dis & ~st_d.gauge.outputs_off;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sdo = st_q.sdo;
  assign fault_n_o = 1'b0;
  assign fault_n_oe = st_q.fault_oe;
  assign gauge = st_q.gauge;
  assign drivers_on = st_q.drv_on;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_sdo_on_fall: assert property (@(posedge mclk) disable iff (reset)
    $changed(sdo) |-> $past(sclk_fall))
    else $error("serial output changed without a falling clock edge");

  chk_sdo_last_stage: assert property (@(posedge mclk) disable iff (reset)
    (ce && sclk_fall) |=> sdo == $past(st_q.shreg[`GSP_MSB]))
    else $error("serial output is not the last stage");

  chk_shift_capture: assert property (@(posedge mclk) disable iff (reset)
    (ce && sclk_rise && pins.load) |=> st_q.shreg[0] == $past(pins.sdi))
    else $error("rising clock did not capture serial input");

  chk_shift_gated: assert property (@(posedge mclk) disable iff (reset)
    !pins.load |=> $stable(st_q.shreg))
    else $error("shift happened with strobe low");

  chk_major_update: assert property (@(posedge mclk) disable iff (reset)
    (ce && load_fall && addr == `GSP_ADDR_MAJOR) |=>
      gauge.major == $past(st_q.shreg[`GSP_DATA_W-1:0]))
    else $error("major gauge not updated on strobe fall");

  chk_hold_stable: assert property (@(posedge mclk) disable iff (reset)
    !load_fall |=> $stable(gauge))
    else $error("holding stage changed without strobe fall");

  chk_addr_off: assert property (@(posedge mclk) disable iff (reset)
    (ce && load_fall && addr == `GSP_ADDR_OFF) |=> ##1 !drivers_on)
    else $error("address 11 did not disable outputs");

  chk_fault_flag: assert property (@(posedge mclk) disable iff (reset)
    (ce && st_q.flt_s2) |=> fault_n_oe)
    else $error("fault flag not pulled low");

  chk_fault_clear: assert property (@(posedge mclk) disable iff (reset)
    (ce && load_fall && !st_q.flt_s2) |=> !st_q.fault_dis)
    else $error("strobe fall did not clear fault disable");

  chk_minor1_load: assert property (@(posedge mclk) disable iff (reset)
    (ce && load_fall && addr == `GSP_ADDR_MINOR1) |=>
      gauge.minor1 == $past(st_q.shreg[`GSP_MINOR_W-1:0]))
    else $error("first minor gauge not updated on strobe fall");

  chk_minor2_load: assert property (@(posedge mclk) disable iff (reset)
    (ce && load_fall && addr == `GSP_ADDR_MINOR2) |=>
      gauge.minor2 == $past(st_q.shreg[`GSP_MINOR_W-1:0]))
    else $error("second minor gauge not updated on strobe fall");

  chk_off_keeps: assert property (@(posedge mclk) disable iff (reset)
    (ce && load_fall && addr == `GSP_ADDR_OFF) |=>
      $stable(gauge.major) && $stable(gauge.minor1) &&
      $stable(gauge.minor2))
    else $error("address 11 changed stored gauge data");

  chk_off_flag: assert property (@(posedge mclk) disable iff (reset)
    (ce && load_fall) |=>
      gauge.outputs_off == ($past(addr) == `GSP_ADDR_OFF))
    else $error("outputs-off flag does not follow the address");

  chk_flag_release: assert property (@(posedge mclk) disable iff (reset)
    (ce && !st_q.flt_s2) |=> !fault_n_oe)
    else $error("fault flag held low without a fault");

  chk_fault_disable: assert property (@(posedge mclk) disable iff (reset)
    (ce && st_q.flt_s2) |=> !drivers_on)
    else $error("fault did not disable the drivers");

  chk_disable_held: assert property (@(posedge mclk) disable iff (reset)
    (st_q.fault_dis && !(ce && load_fall)) |=> st_q.fault_dis)
    else $error("fault disable cleared without strobe fall");

  chk_drv_enable: assert property (@(posedge mclk) disable iff (reset)
    ce |=> drivers_on == (!st_q.fault_dis && !gauge.outputs_off))
    else $error("driver enable disagrees with fault and address");

  chk_ce_freeze: assert property (@(posedge mclk) disable iff (reset)
    !ce |=> $stable(st_q))
    else $error("state moved while clock enable was low");

  chk_shift_order: assert property (@(posedge mclk) disable iff (reset)
    (ce && sclk_rise && pins.load) |=>
      st_q.shreg[`GSP_WORD_W-1:1] == $past(st_q.shreg[`GSP_WORD_W-2:0]))
    else $error("shift register did not move towards the msb");

endmodule

`default_nettype wire

// [verif/gsp_host.sv]
`timescale 1ns/1ps
`default_nettype none

module gsp_host (
  output logic sclk,
  output logic load,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    sclk = 1'b0;
    load = 1'b0;
    sdi = 1'b0;
  end

  task automatic xfer(input logic [11:0] w, output logic [11:0] got);
    // keep pin edges clear of the system clock edges
    #2;
    load = 1'b1;
    for (int i = 11; i >= 0; i--) begin
      sdi = w[i];
      #62.5;
      got[i] = sdo;
      sclk = 1'b1;
      #62.5;
      sclk = 1'b0;
    end
    #62.5;
    load = 1'b0;
    // idle line must not look like the last bit
    sdi = ~sdi;
    #62.5;
  endtask

  // clock pulses with the strobe low, which the device must ignore
  task automatic stray(input int n);
    #2;
    repeat (n) begin
      sdi = ~sdi;
      #62.5;
      sclk = 1'b1;
      #62.5;
      sclk = 1'b0;
    end
    #62.5;
  endtask
endmodule

`default_nettype wire

// [verif/test_gauge_serial_input_port.sv]
`timescale 1ns/1ps
`default_nettype none

module test_gauge_serial_input_port;
  logic mclk, reset, ce, short_det, thermal_sd, sclk, load, sdi;
  logic fault_hold;
  logic sdo, fault_n_o, fault_n_oe, drivers_on;
  gsp_pkg::gsp_gauge_t gauge, exp_g;
  logic [11:0] got, prev;
  logic [15:0] rnd;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  wire logic fault_line = fault_n_oe ? fault_n_o : 1'b1;

  gsp_serial_port gsp_serial_port_i (.mclk(mclk), .reset(reset),
    .ce(ce), .sclk(sclk), .load(load), .sdi(sdi),
    .short_det(short_det), .thermal_sd(thermal_sd), .sdo(sdo),
    .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe), .gauge(gauge),
    .drivers_on(drivers_on));
  gsp_host gsp_host_i (.sclk(sclk), .load(load), .sdi(sdi), .sdo(sdo));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic gsp_pkg::gsp_gauge_t upd(
    input gsp_pkg::gsp_gauge_t g, input logic [11:0] w);
    case (w[11:10])
      2'h0: g.major = w[9:0];
      2'h1: g.minor1 = w[7:0];
      2'h2: g.minor2 = w[7:0];
      default: ;
    endcase
    g.outputs_off = (w[11:10] == 2'h3);
    return g;
  endfunction

  task automatic chk(input string nm, input logic [26:0] e,
    input logic [26:0] s);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic summarize();
    if (n_fail == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic frame(input logic [11:0] w);
    gsp_host_i.xfer(w, got);
    repeat (6) @(negedge mclk);
    exp_g = upd(exp_g, w);
    chk("sdo word", 27'(prev), 27'(got));
    chk("gauge", exp_g, gauge);
    chk("drivers_on", 27'(!exp_g.outputs_off && !fault_hold),
      27'(drivers_on));
    prev = w;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ceiling well above the expected run of about 3700 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    reset = 1'b1;
    ce = 1'b1;
    short_det = 1'b0;
    thermal_sd = 1'b0;
    fault_hold = 1'b0;
    exp_g = '0;
    prev = '0;
    rnd = 16'h0006;
    repeat (16) @(negedge mclk);
    chk("reset gauge", 27'h0, gauge);
    chk("reset outputs", 27'h0, 27'({sdo, fault_n_oe, drivers_on}));
    reset = 1'b0;
    repeat (3) @(negedge mclk);
    chk("drivers_on", 27'h1, 27'(drivers_on));
    frame(12'h3FF);
    frame(12'hFFF);
    frame(12'h5A5);
    frame(12'h8C3);
    // clock enable low: a fault must not reach the flag or the drivers
    ce = 1'b0;
    short_det = 1'b1;
    repeat (8) @(negedge mclk);
    chk("frozen fault pin", 27'h1, 27'(fault_line));
    chk("frozen drivers_on", 27'h1, 27'(drivers_on));
    short_det = 1'b0;
    ce = 1'b1;
    repeat (8) @(negedge mclk);
    chk("drivers_on", 27'h1, 27'(drivers_on));
    // pulses with the strobe low; the next frame shows the word kept
    gsp_host_i.stray(3);
    repeat (6) @(negedge mclk);
    chk("gauge", exp_g, gauge);
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      frame(rnd[11:0]);
    end
    for (int k = 0; k < 2; k++) begin
      {thermal_sd, short_det} = 2'(1 << k);
      repeat (8) @(negedge mclk);
      chk("fault pin", 27'h0, 27'(fault_line));
      chk("drivers_on", 27'h0, 27'(drivers_on));
      {thermal_sd, short_det} = 2'h0;
      repeat (8) @(negedge mclk);
      chk("fault pin", 27'h1, 27'(fault_line));
      chk("drivers_on", 27'h0, 27'(drivers_on));
      frame(12'h123);
    end
    // fault still present at the strobe fall: the set must win
    short_det = 1'b1;
    fault_hold = 1'b1;
    repeat (8) @(negedge mclk);
    frame(12'h0AB);
    short_det = 1'b0;
    fault_hold = 1'b0;
    repeat (8) @(negedge mclk);
    chk("drivers_on", 27'h0, 27'(drivers_on));
    frame(12'h7C4);
    reset = 1'b1;
    repeat (2) @(negedge mclk);
    chk("gauge", 27'h0, gauge);
    chk("reset outputs", 27'h0, 27'({sdo, fault_n_oe, drivers_on}));
    reset = 1'b0;
    exp_g = '0;
    prev = '0;
    repeat (3) @(negedge mclk);
    frame(12'h6AB);
    summarize();
  end
endmodule

`default_nettype wire
